// *** core/wta_map.vh ***
/*
 * Register map, field positions, reset values and scaling constants of the
 * waveform template access block.
 * Assumes inclusion by its bare name from the design file only.
 */
`ifndef WTA_MAP_VH
`define WTA_MAP_VH

`define WTA_ADDR_W 13
`define WTA_CH_NUM 17
`define WTA_CH_LAST 5'h0F
`define WTA_CH_SPARE 5'h10
`define WTA_CH0_COPY 5'h1F

`define WTA_CH_HI 12
`define WTA_CH_LO 8
`define WTA_IDX_HI 7
`define WTA_IDX_LO 2

`define WTA_SEL_CTRL 2'h0
`define WTA_SEL_DATA 2'h1
`define WTA_SEL_PULS 2'h2
`define WTA_SEL_AMPLITUDE_SCALE 2'h3

`define WTA_OFS_PULS 6'h06
`define WTA_OFS_AMPLITUDE_SCALE 6'h07
`define WTA_OFS_CTRL 6'h08
`define WTA_OFS_DATA 6'h09

`define WTA_RST_AMPLITUDE_SCALE 6'h36
`define WTA_RST_PULS 4'h2
`define WTA_RST_ADDR 5'h00
`define WTA_RST_DATA 7'h00

`define WTA_BIT_TMPL 3
`define WTA_BIT_RW 5
`define WTA_BIT_DONE 6

`define WTA_ENTRIES 9'h014
`define WTA_RAM_NUM 340
`define WTA_ENTRY_LAST 5'h13

`define WTA_T1_NOM 10'h036
`define WTA_T1_STEP 10'h002
`define WTA_T1_MAX 10'h014
`define WTA_E1_NOM 10'h021
`define WTA_E1_STEP 10'h003
`define WTA_E1_MAX 10'h064
`define WTA_PCT_MIN 10'h39C

`define WTA_RESP_OKAY 2'h0
`define WTA_RESP_SLVERR 2'h2

`endif

// *** core/wta_top.v ***
/*
 * Per-channel amplitude scaling and indirect template RAM access registers,
 * reached over AXI4-Lite, with the scaled amplitude per channel as output.
 * Channel fields 10H to 1EH are unmapped and answer with SLVERR.
 * Assumes e1_mode comes from logic on sys_clk; one write and one read at most in flight.
 * A bus write runs at most one template RAM access, since the RAM has one write port.
 */
// The AXI4-Lite interface to the registers was decided locally.
// How it works
// - Scaling register is read/write, six-bit factor in bits 5:0, resets to 36H.
// - T1/J1 nominal code 110110; each code step changes amplitude by two percent.
// - T1/J1 amplitude adjustment spans plus twenty down to minus hundred percent.
// - E1 nominal code 100001; each code step changes amplitude by three percent.
// - E1 amplitude adjustment spans plus hundred down to minus hundred percent.
// - Template access fields act only when pulse template select is 1XXX.
// - Control bit 5 picks direction: zero writes RAM, one reads RAM.
// - Address codes 0 to 18 pick entries directly; codes above pick entry 19.
// - Data register holds seven-bit sample in bits 6:0, stored at chosen address.
// - RAM keeps its values until a write access; sample field until a data write or a read access.
// - Sixteen channels each own a scaling copy at 007H upward, plus one at 7C7H.
`timescale 1ns/100ps
`include "wta_map.vh"

module wta_top (
    input wire sys_clk,
    input wire nrst,
    input wire [`WTA_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`WTA_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`WTA_CH_NUM-1:0] e1_mode,
    output reg [8*`WTA_CH_NUM-1:0] amp_pct_ff,
    output reg [`WTA_CH_NUM-1:0] tmpl_en_ff
);

    // Decode: {hit, channel, register}; channel 16 is the extra channel-0 copy
    function [7:0] dec;
        input [`WTA_ADDR_W-1:0] addr;
        reg [4:0] ch;
        reg [5:0] ofs;
        reg hit;
        begin
            ch = addr[`WTA_CH_HI:`WTA_CH_LO];
            ofs = addr[`WTA_IDX_HI:`WTA_IDX_LO];
            hit = (ofs == `WTA_OFS_PULS) || (ofs == `WTA_OFS_AMPLITUDE_SCALE) ||
                  (ofs == `WTA_OFS_CTRL) || (ofs == `WTA_OFS_DATA);
            if (ch == `WTA_CH0_COPY) begin
                ch = `WTA_CH_SPARE;
            end else if (ch > `WTA_CH_LAST) begin
                hit = 1'b0;
            end
            dec = {hit, ch, ofs[1:0]};
        end
    endfunction

    // Entry select saturates so out-of-range codes all land on the last entry
    function [8:0] ram_idx;
        input [4:0] ch;
        input [4:0] samp;
        reg [4:0] ent;
        begin
            ent = (samp > `WTA_ENTRY_LAST) ? `WTA_ENTRY_LAST : samp;
            ram_idx = ({4'h0, ch} * `WTA_ENTRIES) + {4'h0, ent};
        end
    endfunction

    // Signed amplitude change in percent, clamped to the mode's range
    function [7:0] amp_pct;
        input [5:0] code;
        input e1;
        reg [9:0] d;
        reg [9:0] p;
        reg [9:0] lim;
        begin
            if (e1) begin
                d = {4'h0, code} - `WTA_E1_NOM;
                p = d * `WTA_E1_STEP;
                lim = `WTA_E1_MAX;
            end else begin
                d = {4'h0, code} - `WTA_T1_NOM;
                p = d * `WTA_T1_STEP;
                lim = `WTA_T1_MAX;
            end
            if (!p[9] && (p > lim)) begin
                p = lim;
            end else if (p[9] && (p < `WTA_PCT_MIN)) begin
                p = `WTA_PCT_MIN;
            end
            amp_pct = p[7:0];
        end
    endfunction

    reg [5:0] scale_ff [0:`WTA_CH_NUM-1];
    reg [3:0] puls_ff [0:`WTA_CH_NUM-1];
    reg [4:0] samp_ff [0:`WTA_CH_NUM-1];
    reg dir_ff [0:`WTA_CH_NUM-1];
    reg done_ff [0:`WTA_CH_NUM-1];
    reg [6:0] wdat_ff [0:`WTA_CH_NUM-1];
    reg [6:0] ram_ff [0:`WTA_RAM_NUM-1];

    reg aw_full_ff;
    reg [`WTA_ADDR_W-1:0] awaddr_ff;
    reg w_full_ff;
    reg [7:0] wdata_ff;
    reg wstrb0_ff;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_wr = aw_full_ff & w_full_ff & ~s_axi_bvalid;
    wire b_done = s_axi_bvalid & s_axi_bready;
    wire nxt_aw_full = do_wr ? 1'b0 : (aw_take | aw_full_ff);
    wire nxt_w_full = do_wr ? 1'b0 : (w_take | w_full_ff);
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

    wire [7:0] wdec = dec(awaddr_ff);
    wire [4:0] wch = wdec[6:2];
    wire [7:0] rdec = dec(s_axi_araddr);
    wire [4:0] rch = rdec[6:2];
    wire wr_hit = wdec[7];
    wire wr_en = do_wr & wr_hit & wstrb0_ff;
    // Access direction and address come from the word being written
    wire [8:0] acc_idx = ram_idx(wch, wdata_ff[4:0]);
    wire tmpl_on = puls_ff[wch][`WTA_BIT_TMPL];

    reg [7:0] rd_val;
    always @* begin
        case (rdec[1:0])
            `WTA_SEL_PULS: rd_val = {4'h0, puls_ff[rch]};
            `WTA_SEL_AMPLITUDE_SCALE: rd_val = {2'h0, scale_ff[rch]};
            `WTA_SEL_CTRL: rd_val = {1'b0, done_ff[rch], dir_ff[rch], samp_ff[rch]};
            `WTA_SEL_DATA: rd_val = {1'b0, wdat_ff[rch]};
            default: rd_val = 8'h00;
        endcase
    end

    integer i_pl;
    integer i_sc;
    integer i_ct;
    integer i_wd;
    integer i_rm;
    integer i_am;
    integer i_te;

    // Write channels; address and data may arrive in either order
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WTA_RESP_OKAY;
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= 13'h0000;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            s_axi_awready <= ~nxt_aw_full;
            s_axi_wready <= ~nxt_w_full;
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `WTA_RESP_OKAY : `WTA_RESP_SLVERR;
            end else if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel; arready stays low while a response waits for rready
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `WTA_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            s_axi_rvalid <= nxt_rvalid;
            s_axi_arready <= ~nxt_rvalid;
            if (ar_take) begin
                // Unmapped reads return zero with an error response
                s_axi_rdata <= rdec[7] ? {24'h000000, rd_val} : 32'h00000000;
                s_axi_rresp <= rdec[7] ? `WTA_RESP_OKAY : `WTA_RESP_SLVERR;
            end
        end
    end

    // Write strobes, one per register kind of the addressed channel
    wire wr_puls = wr_en & (wdec[1:0] == `WTA_SEL_PULS);
    wire wr_amplitude_scale = wr_en & (wdec[1:0] == `WTA_SEL_AMPLITUDE_SCALE);
    wire wr_data = wr_en & (wdec[1:0] == `WTA_SEL_DATA);
    wire wr_ctrl = wr_en & (wdec[1:0] == `WTA_SEL_CTRL);
    // One RAM port, so a control write runs at most one access
    wire acc_wr = wr_ctrl & tmpl_on & ~wdata_ff[`WTA_BIT_RW];
    wire acc_rd = wr_ctrl & tmpl_on & wdata_ff[`WTA_BIT_RW];

    // Pulse template select per channel
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (i_pl = 0; i_pl < `WTA_CH_NUM; i_pl = i_pl + 1) begin
                puls_ff[i_pl] <= `WTA_RST_PULS;
            end
        end else if (wr_puls) begin
            puls_ff[wch] <= wdata_ff[3:0];
        end
    end

    // Amplitude scaling, one copy per channel plus the channel-0 copy
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (i_sc = 0; i_sc < `WTA_CH_NUM; i_sc = i_sc + 1) begin
                scale_ff[i_sc] <= `WTA_RST_AMPLITUDE_SCALE;
            end
        end else if (wr_amplitude_scale) begin
            scale_ff[wch] <= wdata_ff[5:0];
        end
    end

    // Access control word; address and direction are kept even when no access runs
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (i_ct = 0; i_ct < `WTA_CH_NUM; i_ct = i_ct + 1) begin
                samp_ff[i_ct] <= `WTA_RST_ADDR;
                dir_ff[i_ct] <= 1'b0;
                done_ff[i_ct] <= 1'b0;
            end
        end else if (wr_ctrl) begin
            samp_ff[wch] <= wdata_ff[4:0];
            dir_ff[wch] <= wdata_ff[`WTA_BIT_RW];
            // Completion reads back set only if an access really ran
            done_ff[wch] <= tmpl_on;
        end
    end

    // Sample value: the host writes it, a read access overwrites it
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (i_wd = 0; i_wd < `WTA_CH_NUM; i_wd = i_wd + 1) begin
                wdat_ff[i_wd] <= `WTA_RST_DATA;
            end
        end else if (wr_data) begin
            wdat_ff[wch] <= wdata_ff[6:0];
        end else if (acc_rd) begin
            wdat_ff[wch] <= ram_ff[acc_idx];
        end
    end

    // Template RAM, changed only by a write access
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (i_rm = 0; i_rm < `WTA_RAM_NUM; i_rm = i_rm + 1) begin
                ram_ff[i_rm] <= `WTA_RST_DATA;
            end
        end else if (acc_wr) begin
            ram_ff[acc_idx] <= wdat_ff[wch];
        end
    end

    // Amplitude change per channel, seen by the pulse shaper
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            amp_pct_ff <= {8*`WTA_CH_NUM{1'b0}};
        end else begin
            for (i_am = 0; i_am < `WTA_CH_NUM; i_am = i_am + 1) begin
                amp_pct_ff[8*i_am +: 8] <= amp_pct(scale_ff[i_am], e1_mode[i_am]);
            end
        end
    end

    // Template enable per channel; only the top select bit matters
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tmpl_en_ff <= {`WTA_CH_NUM{1'b0}};
        end else begin
            for (i_te = 0; i_te < `WTA_CH_NUM; i_te = i_te + 1) begin
                tmpl_en_ff[i_te] <= puls_ff[i_te][`WTA_BIT_TMPL];
            end
        end
    end

endmodule // wta_top

// *** testbench/wta_properties.sv ***
/* Checker for the bus handshake and the channel-0 amplitude output of wta_top.
   Assumes it is bound into wta_top by the statement at the foot. */
`timescale 1ns/100ps
module wta_chk (
    input wire sys_clk,
    input wire nrst,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire [16:0] e1_mode,
    input wire [135:0] amp_pct_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire signed [7:0] amp0 = amp_pct_ff[7:0];
    a_t1_range: assert property (!$past(e1_mode[0]) |-> amp0 >= -100 && amp0 <= 20)
        else $error("t1 amplitude out of range");
    a_t1_step: assert property (!$past(e1_mode[0]) |-> !amp0[0])
        else $error("t1 amplitude not in two percent steps");
    a_e1_range: assert property ($past(e1_mode[0]) |-> amp0 >= -100 && amp0 <= 100)
        else $error("e1 amplitude out of range");
    a_e1_step: assert property ($past(e1_mode[0]) && amp0 != 100 && amp0 != -100 |-> amp0 % 3 == 0)
        else $error("e1 amplitude not in three percent steps");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
        else $error("read data upper bits set");
endmodule // wta_chk
bind wta_top wta_chk chk_u (.*);

// *** testbench/waveform_template_access_test.sv ***
/* Random and corner-case bench for wta_top.
   Assumes the map header is on the include path. */
`timescale 1ns/100ps
module waveform_template_access_test;
    logic sys_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [12:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 32'h8A9A9120;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [16:0] e1_mode = 0, tmpl_en_ff;
    logic [135:0] amp_pct_ff;
    logic [6:0] ram [20] = '{default: 0};
    logic [5:0] sc [17];
    int miscompares = 0, n_tests = 0, c, e;
    wta_top dut_u (.*);
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function logic [12:0] ad(input int ch, input int o);
        return 13'((ch == 16 ? 'h1F00 : ch << 8) | (o << 2));
    endfunction
    function logic [7:0] amp_exp(input logic e1, input logic [5:0] cd);
        int v;
        v = e1 ? (int'(cd) - 33) * 3 : (int'(cd) - 54) * 2;
        if (v > (e1 ? 100 : 20)) v = e1 ? 100 : 20;
        if (v < -100) v = -100;
        return v[7:0];
    endfunction
    task summarize;
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task tick(inout int n);
        @(posedge sys_clk);
        n++;
        if (n > 200) begin
            miscompares++;
            summarize();
        end
    endtask
    // One write at a time; the leading edge keeps bready from being set twice in one step
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        int n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [12:0] a);
        int n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1;
        e1_mode <= seed[16:0];
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 17; i++) begin
            rd(ad(i, 7));
            chk("scale_reset", 32'h36, d);
            rd(ad(i, 9));
            chk("sample_reset", 0, d);
            seed = lfsr(seed);
            sc[i] = i == 0 ? 6'h3F : i == 1 ? 6'h00 : i == 2 ? 6'h21 : i == 3 ? 6'h36 : seed[5:0];
            wr(ad(i, 7), {2'b11, sc[i]});
            chk("bresp", 0, resp);
            rd(ad(i, 7));
            chk("scale", {26'h0, sc[i]}, d);
            chk("rresp", 0, resp);
        end
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 17; i++) chk("amp", amp_exp(e1_mode[i], sc[i]), amp_pct_ff[8*i+:8]);
        // Swap every channel's mode; those now in E1 get the E1 nominal, as software must
        e1_mode <= ~e1_mode;
        @(posedge sys_clk);
        for (int i = 0; i < 17; i++) begin
            if (e1_mode[i]) begin
                sc[i] = 6'h21;
                wr(ad(i, 7), 8'h21);
            end
        end
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 17; i++) chk("amp_swap", amp_exp(e1_mode[i], sc[i]), amp_pct_ff[8*i+:8]);
        s_axi_wstrb <= 4'h0;
        wr(ad(1, 7), 8'h3F);
        chk("bresp_nostrobe", 0, resp);
        s_axi_wstrb <= 4'hF;
        rd(ad(1, 7));
        chk("scale_nostrobe", {26'h0, sc[1]}, d);
        wr(13'h101C, 8'h55);
        chk("bresp_unmapped", 2, resp);
        rd(13'h101C);
        chk("rresp_unmapped", 2, resp);
        c = seed[3:0];
        wr(ad(c, 6), 8'h08);
        repeat (2) @(posedge sys_clk);
        chk("tmpl_en_on", 1, tmpl_en_ff[c]);
        // Codes past 18 share entry 19, so the model folds them the same way
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            e = k == 0 ? 0 : k == 1 ? 18 : k == 2 ? 19 : k == 3 ? 31 : seed[12:8];
            wr(ad(c, 9), {1'b0, seed[6:0]});
            wr(ad(c, 8), 8'(e));
            ram[e > 19 ? 19 : e] = seed[6:0];
        end
        for (e = 0; e < 32; e++) begin
            wr(ad(c, 8), 8'(8'h20 | e));
            rd(ad(c, 9));
            chk("sample", ram[e > 19 ? 19 : e], d);
            rd(ad(c, 8));
            chk("control", 8'h60 | e, d);
        end
        wr(ad(c, 6), 8'h02);
        repeat (2) @(posedge sys_clk);
        chk("tmpl_en_off", 0, tmpl_en_ff[c]);
        wr(ad(c, 8), 8'h20);
        rd(ad(c, 9));
        chk("sample_kept", ram[19], d);
        rd(ad(c, 8));
        chk("done_off", 0, d & 8'h40);
        summarize();
    end
endmodule // waveform_template_access_test
